// *** hdl/wrb_top.v ***
// Word register bank with batch shift, batch clear and indirect access
//
// Local design decisions: the strobed register port and the register offsets.
`default_nettype none

`include "wrb_defs.vh"

module wrb_top #(
	parameter [6:0] BACKUP_FIRST = `WRB_BACKUP_NONE
) (
	// Clock and reset
	input  wire        mclk_in,
	input  wire        rst_in,
	// Register port
	input  wire [7:0]  reg_addr_in,
	input  wire [15:0] reg_wdata_in,
	input  wire        reg_wr_in,
	input  wire        reg_rd_in,
	output reg  [15:0] reg_rdata_out,
	// Shift trigger
	input  wire        shift_trigger_relay_in,
	// Timer/counter load notice
	output reg         tc_load_out,
	output reg  [6:0]  tc_load_index_out,
	output reg  [15:0] tc_load_value_out,
	// Step status
	output reg         op_done_out,
	output reg         op_refused_out
);

	// ----------------------------------------------------------------
	// Helper functions
	// ----------------------------------------------------------------
	function range_fits;
		input [15:0] first;
		input [15:0] count;
		reg   [16:0] last_end;
		begin
			last_end  = {1'b0, first} + {1'b0, count};
			range_fits = (first < `WRB_WORD_LIMIT) && (last_end <= `WRB_END_LIMIT);
		end
	endfunction

	function in_range;
		input [6:0]  idx;
		input [15:0] first;
		input [15:0] count;
		reg   [16:0] last_end;
		reg   [16:0] wide_idx;
		begin
			last_end = {1'b0, first} + {1'b0, count};
			wide_idx = {10'h000, idx};
			in_range = (wide_idx >= {1'b0, first}) && (wide_idx < last_end);
		end
	endfunction

	function [1:0] number_kind;
		input [15:0] num;
		begin
			if (num <= `WRB_TC_LIMIT) begin
				number_kind = `WRB_KIND_TC;
			end else if ((num >= `WRB_DNUM_BASE) && (num <= `WRB_DNUM_TOP)) begin
				number_kind = `WRB_KIND_DATA;
			end else begin
				number_kind = `WRB_KIND_BAD;
			end
		end
	endfunction

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	reg  [15:0] word_q [0:`WRB_NUM_WORDS-1];
	reg  [15:0] word_d [0:`WRB_NUM_WORDS-1];
	reg  [15:0] first_q;
	reg  [15:0] first_d;
	reg  [15:0] count_q;
	reg  [15:0] count_d;
	reg  [15:0] dir_q;
	reg  [15:0] dir_d;
	reg         pend_q;
	reg         pend_d;
	reg         refused_q;
	reg         refused_d;
	reg  [3:0]  last_cmd_q;
	reg  [3:0]  last_cmd_d;
	reg         rd_pend_q;
	reg  [7:0]  rd_addr_q;

	wire [15:0] tc_rdata;
	wire [15:0] count_eff;
	wire [1:0]  kind;
	wire [15:0] dnum_off;
	wire [6:0]  dnum_idx;
	wire [15:0] word_off;
	wire [6:0]  word_idx;
	wire        wr_first;
	wire        wr_count;
	wire        wr_dir;
	wire        wr_cmd;
	wire        wr_word;
	wire        do_shift;
	wire        do_clear;
	wire        do_iread;
	wire        do_iwrite;
	wire        shift_ok;
	wire        clear_ok;
	wire        dir_ok;
	wire [16:0] shift_end;
	wire [6:0]  shift_top;
	wire        tc_we;
	reg  [6:0]  lo_nb;
	reg  [6:0]  hi_nb;

	// ----------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------
	// A counter read lands one cycle late; later steps see it through here
	assign count_eff = pend_q ? tc_rdata : count_q;

	assign wr_first = reg_wr_in && (reg_addr_in == `WRB_REG_FIRST);
	assign wr_count = reg_wr_in && (reg_addr_in == `WRB_REG_COUNT);
	assign wr_dir   = reg_wr_in && (reg_addr_in == `WRB_REG_DIR);
	assign wr_cmd   = reg_wr_in && (reg_addr_in == `WRB_REG_CMD);
	assign wr_word  = reg_wr_in && (reg_addr_in >= `WRB_REG_WORD_BASE) &&
	                  (reg_addr_in <= `WRB_REG_WORD_TOP);
	assign word_off = {8'h00, reg_addr_in} - {8'h00, `WRB_REG_WORD_BASE};
	assign word_idx = word_off[6:0];

	// Lowest command bit wins when software sets several at once
	assign do_shift  = shift_trigger_relay_in ||
	                   (wr_cmd && reg_wdata_in[`WRB_CMD_SHIFT]);
	assign do_clear  = !do_shift && wr_cmd && reg_wdata_in[`WRB_CMD_CLEAR];
	assign do_iread  = !do_shift && !do_clear && wr_cmd &&
	                   reg_wdata_in[`WRB_CMD_IREAD];
	assign do_iwrite = !do_shift && !do_clear && !do_iread && wr_cmd &&
	                   reg_wdata_in[`WRB_CMD_IWRITE];

	assign dir_ok    = (dir_q == `WRB_DIR_UP) || (dir_q == `WRB_DIR_DOWN);
	assign shift_ok  = range_fits(first_q, count_eff) && dir_ok;
	assign clear_ok  = range_fits(first_q, count_eff);
	assign shift_end = {1'b0, first_q} + {1'b0, count_eff} - 17'h00001;
	assign shift_top = shift_end[6:0];

	// Numbers 0 to 127 name a counter, 1000 to 1095 a data word, all others are refused
	assign kind     = number_kind(first_q);
	assign dnum_off = first_q - `WRB_DNUM_BASE;
	assign dnum_idx = dnum_off[6:0];

	// Only the counter store and the word bank can be targets
	assign tc_we = do_iwrite && (kind == `WRB_KIND_TC);

	// ----------------------------------------------------------------
	// Counter value store
	// ----------------------------------------------------------------
	wrb_tc_mem u_tc_mem (
		.mclk_in     (mclk_in),
		.wr_en_in    (tc_we),
		.wr_addr_in  (first_q[6:0]),
		.wr_data_in  (count_eff),
		.rd_addr_in  (first_q[6:0]),
		.rd_data_out (tc_rdata)
	);

	// ----------------------------------------------------------------
	// Word bank next state
	// ----------------------------------------------------------------
	integer i;
	always @* begin
		lo_nb = 7'h00;
		hi_nb = 7'h00;
		for (i = 0; i < `WRB_NUM_WORDS; i = i + 1) begin
			word_d[i] = word_q[i];
		end
		if (do_shift && shift_ok) begin
			for (i = 0; i < `WRB_NUM_WORDS; i = i + 1) begin
				// Every word in the range takes its neighbour, or zero at the vacated end, in the same edge
				// Neighbour index is a variable so no constant select leaves the bank
				lo_nb = i[6:0] - 7'h01;
				hi_nb = i[6:0] + 7'h01;
				if (in_range(i[6:0], first_q, count_eff)) begin
					if (dir_q == `WRB_DIR_UP) begin
						if (i[6:0] == first_q[6:0]) begin
							word_d[i] = `WRB_ZERO_WORD;
						end else begin
							word_d[i] = word_q[lo_nb];
						end
					end else begin
						if (i[6:0] == shift_top) begin
							word_d[i] = `WRB_ZERO_WORD;
						end else begin
							word_d[i] = word_q[hi_nb];
						end
					end
				end
			end
		end else if (do_clear && clear_ok) begin
			for (i = 0; i < `WRB_NUM_WORDS; i = i + 1) begin
				if (in_range(i[6:0], first_q, count_eff)) begin
					word_d[i] = `WRB_ZERO_WORD;
				end
			end
		end else if (do_iwrite && (kind == `WRB_KIND_DATA)) begin
			word_d[dnum_idx] = count_eff;
		end
		// Direct bus write lands after any operation on the same word
		if (wr_word) begin
			word_d[word_idx] = reg_wdata_in;
		end
	end

	// ----------------------------------------------------------------
	// Parameter words and status next state
	// ----------------------------------------------------------------
	always @* begin
		first_d    = wr_first ? reg_wdata_in : first_q;
		dir_d      = wr_dir ? reg_wdata_in : dir_q;
		count_d    = count_eff;
		pend_d     = 1'b0;
		refused_d  = refused_q;
		last_cmd_d = last_cmd_q;
		if (do_iread) begin
			if (kind == `WRB_KIND_TC) begin
				pend_d = 1'b1;
			end else if (kind == `WRB_KIND_DATA) begin
				count_d = word_q[dnum_idx];
			end
		end
		if (wr_count) begin
			count_d = reg_wdata_in;
			pend_d  = 1'b0;
		end
		if (do_shift) begin
			refused_d  = !shift_ok;
			last_cmd_d = `WRB_LAST_SHIFT;
		end else if (do_clear) begin
			refused_d  = !clear_ok;
			last_cmd_d = `WRB_LAST_CLEAR;
		end else if (do_iread) begin
			refused_d  = (kind == `WRB_KIND_BAD);
			last_cmd_d = `WRB_LAST_IREAD;
		end else if (do_iwrite) begin
			refused_d  = (kind == `WRB_KIND_BAD);
			last_cmd_d = `WRB_LAST_IWRITE;
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always @(posedge mclk_in) begin
		if (rst_in) begin
			first_q    <= `WRB_ZERO_WORD;
			count_q    <= `WRB_ZERO_WORD;
			dir_q      <= `WRB_ZERO_WORD;
			pend_q     <= 1'b0;
			refused_q  <= 1'b0;
			last_cmd_q <= `WRB_LAST_NONE;
		end else begin
			first_q    <= first_d;
			count_q    <= count_d;
			dir_q      <= dir_d;
			pend_q     <= pend_d;
			refused_q  <= refused_d;
			last_cmd_q <= last_cmd_d;
		end
	end

	integer k;
	always @(posedge mclk_in) begin
		for (k = 0; k < `WRB_NUM_WORDS; k = k + 1) begin
			// Backed-up words ride through reset untouched
			if (rst_in && (k[6:0] < BACKUP_FIRST)) begin
				word_q[k] <= `WRB_ZERO_WORD;
			end else if (!rst_in) begin
				word_q[k] <= word_d[k];
			end
		end
	end

	// ----------------------------------------------------------------
	// Step outputs and counter load notice
	// ----------------------------------------------------------------
	// Pulses stand one cycle; the status word keeps the last verdict
	always @(posedge mclk_in) begin
		if (rst_in) begin
			op_done_out       <= 1'b0;
			op_refused_out    <= 1'b0;
			tc_load_out       <= 1'b0;
			tc_load_index_out <= 7'h00;
			tc_load_value_out <= `WRB_ZERO_WORD;
		end else begin
			op_done_out       <= (do_shift && shift_ok) || (do_clear && clear_ok) ||
			                     ((do_iread || do_iwrite) && (kind != `WRB_KIND_BAD));
			op_refused_out    <= (do_shift && !shift_ok) || (do_clear && !clear_ok) ||
			                     ((do_iread || do_iwrite) && (kind == `WRB_KIND_BAD));
			tc_load_out       <= tc_we;
			tc_load_index_out <= first_q[6:0];
			tc_load_value_out <= count_eff;
		end
	end

	// ----------------------------------------------------------------
	// Register read port
	// ----------------------------------------------------------------
	// Command register and unused places read as zero
	reg [15:0] rd_mux;
	wire [15:0] rd_off;
	assign rd_off = {8'h00, rd_addr_q} - {8'h00, `WRB_REG_WORD_BASE};

	always @(posedge mclk_in) begin
		if (rst_in) begin
			rd_pend_q <= 1'b0;
			rd_addr_q <= `WRB_ZERO_BYTE;
		end else begin
			rd_pend_q <= reg_rd_in;
			rd_addr_q <= reg_addr_in;
		end
	end

	// Muxed after the edge so a landing counter value is already visible
	always @* begin
		rd_mux = `WRB_ZERO_WORD;
		if (rd_addr_q == `WRB_REG_FIRST) begin
			rd_mux = first_q;
		end else if (rd_addr_q == `WRB_REG_COUNT) begin
			rd_mux = count_eff;
		end else if (rd_addr_q == `WRB_REG_DIR) begin
			rd_mux = dir_q;
		end else if (rd_addr_q == `WRB_REG_STATUS) begin
			rd_mux = {8'h00, last_cmd_q, 2'b00, pend_q, refused_q};
		end else if ((rd_addr_q >= `WRB_REG_WORD_BASE) &&
		             (rd_addr_q <= `WRB_REG_WORD_TOP)) begin
			rd_mux = word_q[rd_off[6:0]];
		end
	end

	always @* begin
		reg_rdata_out = rd_pend_q ? rd_mux : `WRB_ZERO_WORD;
	end

endmodule

`default_nettype wire

// *** hdl/wrb_defs.vh ***
// Constants shared by the word register batch operation block
`ifndef WRB_DEFS_VH
`define WRB_DEFS_VH

// ----------------------------------------------------------------
// Geometry
// ----------------------------------------------------------------
`define WRB_DATA_W        16
`define WRB_ADDR_W        8
`define WRB_NUM_WORDS     96
`define WRB_WORD_LIMIT    16'd96
`define WRB_END_LIMIT     17'd96
`define WRB_TC_DEPTH      128
`define WRB_TC_LIMIT      16'd127
`define WRB_DNUM_BASE     16'h03E8
`define WRB_DNUM_TOP      16'h0447

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define WRB_REG_FIRST     8'h00
`define WRB_REG_COUNT     8'h01
`define WRB_REG_DIR       8'h02
`define WRB_REG_CMD       8'h03
`define WRB_REG_STATUS    8'h04
`define WRB_REG_WORD_BASE 8'h80
`define WRB_REG_WORD_TOP  8'hDF

// ----------------------------------------------------------------
// Command bits, direction codes, number kinds
// ----------------------------------------------------------------
`define WRB_CMD_SHIFT     0
`define WRB_CMD_CLEAR     1
`define WRB_CMD_IREAD     2
`define WRB_CMD_IWRITE    3
`define WRB_DIR_UP        16'h0000
`define WRB_DIR_DOWN      16'h0001
`define WRB_KIND_BAD      2'h0
`define WRB_KIND_TC       2'h1
`define WRB_KIND_DATA     2'h2
`define WRB_LAST_NONE     4'h0
`define WRB_LAST_SHIFT    4'h1
`define WRB_LAST_CLEAR    4'h2
`define WRB_LAST_IREAD    4'h4
`define WRB_LAST_IWRITE   4'h8

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define WRB_ZERO_WORD     16'h0000
`define WRB_ZERO_BYTE     8'h00
`define WRB_BACKUP_NONE   7'h60

`endif

// *** hdl/wrb_tc_mem.v ***
// Timer/counter current value store with registered read data
`default_nettype none

`include "wrb_defs.vh"

module wrb_tc_mem (
	// Clock
	input  wire        mclk_in,
	// Write port
	input  wire        wr_en_in,
	input  wire [6:0]  wr_addr_in,
	input  wire [15:0] wr_data_in,
	// Read port
	input  wire [6:0]  rd_addr_in,
	output reg  [15:0] rd_data_out
);

	reg [15:0] mem_q [0:`WRB_TC_DEPTH-1];

	// No reset: current values belong to the timer logic, not to reset
	always @(posedge mclk_in) begin
		if (wr_en_in) begin
			mem_q[wr_addr_in] <= wr_data_in;
		end
		rd_data_out <= mem_q[rd_addr_in];
	end

endmodule

`default_nettype wire

// *** verification/wrb_top_asserts.sv ***
// Checker for the word register batch operation block
`default_nettype none

module wrb_top_chk (
	// Clock and reset
	input wire logic        mclk_in,
	input wire logic        rst_in,
	// Register port
	input wire logic [7:0]  reg_addr_in,
	input wire logic [15:0] reg_wdata_in,
	input wire logic        reg_wr_in,
	input wire logic        reg_rd_in,
	input wire logic [15:0] reg_rdata_out,
	// Trigger and status
	input wire logic        shift_trigger_relay_in,
	input wire logic        tc_load_out,
	input wire logic        op_done_out,
	input wire logic        op_refused_out
);
	timeunit 1ns;
	timeprecision 1ps;

	wire logic cmd_w = reg_wr_in && reg_addr_in == 8'h03 && reg_wdata_in[3:0] != 4'h0;

	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (rst_in);

	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	AST_RDATA_IDLE: assert property (
		!reg_rd_in |=> reg_rdata_out == 16'h0000)
		else $error("read data not zero outside read slot");
	AST_ONE_ANSWER: assert property (
		!(op_done_out && op_refused_out))
		else $error("done and refused together");
	AST_CMD_ANSWER: assert property (
		cmd_w |=> op_done_out || op_refused_out)
		else $error("command got no answer");
	AST_SHIFT_ANSWER: assert property (
		shift_trigger_relay_in |-> ##1 (op_done_out || op_refused_out))
		else $error("trigger got no answer");
	AST_NO_CAUSE: assert property (
		(op_done_out || op_refused_out) |-> $past(cmd_w || shift_trigger_relay_in))
		else $error("answer without request");
	AST_TC_CAUSE: assert property (
		tc_load_out |-> op_done_out && $past(cmd_w && reg_wdata_in[3:0] == 4'h8))
		else $error("counter load without indirect write");
	AST_TC_REFUSED: assert property (
		op_refused_out |-> !tc_load_out)
		else $error("refused write loaded a counter");
	// Empty places must read as zero
	AST_READ_ZERO: assert property (
		reg_rd_in && (reg_addr_in == 8'h03 ||
		reg_addr_in inside {[8'h05:8'h7F], [8'hE0:8'hFF]}) |=> reg_rdata_out == 16'h0000)
		else $error("empty address read nonzero");
endmodule

bind wrb_top wrb_top_chk i_chk (.mclk_in, .rst_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
	.reg_rd_in, .reg_rdata_out, .shift_trigger_relay_in, .tc_load_out, .op_done_out,
	.op_refused_out);

`default_nettype wire

// *** verification/wrb_top_test.sv ***
// Self-checking bench for the word register batch operation block
`default_nettype none

module wrb_top_test;
	timeunit 1ns;
	timeprecision 1ps;

	logic             mclk_in = 1'b0;
	logic             rst_in = 1'b1;
	logic [7:0]       addr = 8'h00;
	logic [15:0]      wdata = 16'h0000;
	logic             wr = 1'b0;
	logic             rd = 1'b0;
	logic             trig = 1'b0;
	wire logic [15:0] rdata;
	wire logic        tc_ld;
	wire logic [6:0]  tc_idx;
	wire logic [15:0] tc_val;
	wire logic        done;
	wire logic        refused;
	logic [15:0]      m [0:95];
	int               num_errors = 0;
	int               cmp_count = 0;
	int               i;

	always #5 mclk_in = ~mclk_in;

	wrb_top #(.BACKUP_FIRST(7'h5A)) i_dut (.mclk_in(mclk_in), .rst_in(rst_in),
		.reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
		.reg_rdata_out(rdata), .shift_trigger_relay_in(trig), .tc_load_out(tc_ld),
		.tc_load_index_out(tc_idx), .tc_load_value_out(tc_val), .op_done_out(done),
		.op_refused_out(refused));

	// ----------------------------------------------------------------
	// Access tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr_reg(input logic [7:0] a, input logic [15:0] v);
		@(posedge mclk_in);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge mclk_in);
		wr <= 1'b0;
		#1;
	endtask

	task automatic chk_reg(input logic [7:0] a, input logic [15:0] exp);
		@(posedge mclk_in);
		addr <= a;
		rd <= 1'b1;
		@(posedge mclk_in);
		rd <= 1'b0;
		#1;
		chk(rdata, exp);
	endtask

	// Command 0 means the pin trigger, held for exactly one cycle
	task automatic op(input logic [15:0] f, c, dn, input logic [3:0] cmd, input logic ok);
		wr_reg(8'h00, f);
		wr_reg(8'h01, c);
		wr_reg(8'h02, dn);
		if (cmd == 4'h0) begin
			@(posedge mclk_in);
			trig <= 1'b1;
			@(posedge mclk_in);
			trig <= 1'b0;
			#1;
		end else begin
			wr_reg(8'h03, {12'h000, cmd});
		end
		chk(done, ok);
		chk(refused, !ok);
	endtask

	task automatic mshift(input int f, input int c, input int dn);
		if (dn == 0) begin
			for (int k = f + c - 1; k > f; k--) m[k] = m[k - 1];
			m[f] = 16'h0000;
		end else begin
			for (int k = f; k < f + c - 1; k++) m[k] = m[k + 1];
			m[f + c - 1] = 16'h0000;
		end
	endtask

	task automatic verify_all();
		for (int k = 0; k < 96; k++) chk_reg(8'h80 + k[7:0], m[k]);
	endtask

	task automatic results();
		$display("comparisons %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial begin
		repeat (3) @(posedge mclk_in);
		rst_in <= 1'b0;
		for (i = 0; i < 96; i++) begin
			m[i] = 16'hA000 + i[15:0];
			wr_reg(8'h80 + i[7:0], m[i]);
		end
		op(16'h0039, 16'h0010, 16'h0000, 4'h0, 1'b1);
		mshift(57, 16, 0);
		verify_all();
		m[57] = 16'hC0DE;
		wr_reg(8'hB9, m[57]);
		chk_reg(8'hB9, 16'hC0DE);
		op(16'h0039, 16'h0010, 16'h0001, 4'h0, 1'b1);
		mshift(57, 16, 1);
		verify_all();
		$display("test shift done");
		op(16'h0050, 16'h0010, 16'h0000, 4'h1, 1'b1);
		mshift(80, 16, 0);
		op(16'h0051, 16'h0010, 16'h0000, 4'h0, 1'b0);
		op(16'h0039, 16'h0004, 16'h0002, 4'h0, 1'b0);
		verify_all();
		$display("test shift limits done");
		op(16'h002D, 16'h0014, 16'h0000, 4'h2, 1'b1);
		for (i = 45; i < 65; i++) m[i] = 16'h0000;
		op(16'h005A, 16'h0007, 16'h0000, 4'h2, 1'b0);
		verify_all();
		$display("test clear done");
		op(16'h0428, 16'h5A5A, 16'h0000, 4'h8, 1'b1);
		chk(tc_ld, 1'b0);
		op(16'h0447, 16'hBEEF, 16'h0000, 4'h8, 1'b1);
		chk(tc_ld, 1'b0);
		m[64] = 16'h5A5A;
		m[95] = 16'hBEEF;
		op(16'h0005, 16'h1234, 16'h0000, 4'h8, 1'b1);
		chk(tc_ld, 1'b1);
		chk(tc_idx, 16'h0005);
		chk(tc_val, 16'h1234);
		op(16'h007F, 16'h4321, 16'h0000, 4'h8, 1'b1);
		chk(tc_idx, 16'h007F);
		op(16'h0448, 16'h7777, 16'h0000, 4'h8, 1'b0);
		op(16'h0080, 16'h7777, 16'h0000, 4'h8, 1'b0);
		chk(tc_ld, 1'b0);
		$display("test indirect write done");
		op(16'h0005, 16'h0000, 16'h0000, 4'h4, 1'b1);
		chk_reg(8'h01, 16'h1234);
		op(16'h0428, 16'h0000, 16'h0000, 4'h4, 1'b1);
		chk_reg(8'h01, 16'h5A5A);
		op(16'h0448, 16'h0001, 16'h0000, 4'h4, 1'b0);
		op(16'h0080, 16'h0001, 16'h0000, 4'h4, 1'b0);
		chk_reg(8'h04, 16'h0041);
		chk_reg(8'h01, 16'h0001);
		verify_all();
		$display("test indirect read done");
		chk_reg(8'h03, 16'h0000);
		wr_reg(8'h05, 16'hFFFF);
		chk_reg(8'h05, 16'h0000);
		$display("test map done");
		@(posedge mclk_in);
		rst_in <= 1'b1;
		repeat (3) @(posedge mclk_in);
		rst_in <= 1'b0;
		for (i = 0; i < 90; i++) m[i] = 16'h0000;
		verify_all();
		chk_reg(8'h00, 16'h0000);
		$display("test reset done");
		results();
	end

	// Whole run needs well under 30 us
	initial begin
		#200000;
		num_errors++;
		results();
	end
endmodule

`default_nettype wire
